// file: rtl/measurement_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - third control bit selects internal reference when clear, supply rail when set
// - pin pair field picks external diode or analog inputs one and two
// - analog results are 10-bit straight binary, LSB is reference over 1024
// - high flag when result above high limit, low flag when at or below low
// - limits are 8 bits, analog results are 10 bits
// - unmasked analog and temperature violations set first status register flags
// - any unmasked flag drives alert to its polarity-selected active level
// - single-channel mode repeatedly converts only the selected channel
// - round robin: supply, internal, external or inputs one/two, three, four
// - round robin runs continuously, both temperatures every pass while the pin pair is set to the external diode
// - temperatures compared with their own limits, unmasked violations set flags
// - temperature spans -128 to +127 degrees with quarter-degree steps
// - with averaging on, sixteen samples are taken and averaged
// - averaging on after reset, one second-control bit disables it
// - finished temperature result is loaded into its readable value register
// - serial activity aborts conversion and resets the converter, restart after
// - supply result split: two low bits in one register, eight high in another
// - unmasked supply violation sets second status flag and feeds alert
// - supply conversion always uses internal reference, scaled so 7 V is full scale
// - DAC code is temperature minus zero-volt temperature, 1 or 0.25 degree LSB
// - DAC code saturates at full scale instead of wrapping
// - after reset round robin, monitoring off until conversion-enable bit set
// - single-channel mode bit disables round robin sequencing
// - internal temperature stored two's complement after adding offset register
module measurement_sequencer_monitor (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     nrst,
  // register access from the serial interface logic
  input  wire logic                     hostActive,
  input  wire msm_pkg::msm_reg_req_type regReq,
  output var  logic [7:0]               regRdData,
  // converter front end
  output var  msm_pkg::msm_adc_ctl_type adcCtl,
  input  wire msm_pkg::msm_adc_res_type adcRes,
  // thermal voltage outputs and alert
  output var  msm_pkg::msm_dac_type     dacOut,
  output var  logic                     alert
);
  import msm_pkg::*;

  msm_state_all_type s_q;
  msm_state_all_type s_d;

  logic              pinsAnalog;
  logic              singleMode;
  logic              avgOff;
  msm_chan_type      convChan;
  logic [9:0]        avgRes;
  logic [9:0]        storeVal;
  logic [7:0]        cmpVal;
  logic [7:0]        limHi;
  logic [7:0]        limLo;
  logic              isTemp;
  logic              overHi;
  logic              underLo;
  logic [7:0]        s1Set;
  logic [7:0]        s2Set;
  logic [7:0]        s1Clr;
  logic [7:0]        s2Clr;
  logic [7:0]        s1Next;
  logic [7:0]        s2Next;
  logic              anyFlag;
  msm_chan_type      roundChan;
  logic [9:0]        dacCode;
  logic [7:0]        rdMux;
  logic [7:0]        limIdx;

  function automatic msm_chan_type nextChan(input msm_chan_type ch, input logic analog);
    case (ch)
      CH_SUPPLY: nextChan = CH_INT;
      CH_INT:    nextChan = analog ? CH_ANALOG_INPUT_ONE : CH_EXT;
      CH_EXT:    nextChan = CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_ONE:   nextChan = CH_ANALOG_INPUT_TWO;
      CH_ANALOG_INPUT_TWO:   nextChan = CH_ANALOG_INPUT_THREE;
      CH_ANALOG_INPUT_THREE:   nextChan = CH_ANALOG_INPUT_FOUR;
      default:   nextChan = CH_SUPPLY;
    endcase
  endfunction : nextChan

  // DAC code for one temperature result and its zero-volt offset
  function automatic logic [9:0] dacMap(input logic [9:0] t, input logic [7:0] ofs, input logic ten);
    logic [11:0] diff;
    diff = 12'h000;
    if (ten) begin
      diff = {{2{t[9]}}, t} - {{2{ofs[7]}}, ofs, 2'b00};
      if (diff[11])
        dacMap = 10'h000;
      else if (diff > {2'b00, DAC10_FULL})
        dacMap = DAC10_FULL;
      else
        dacMap = diff[9:0];
    end else begin
      diff = {{4{t[9]}}, t[9:2]} - {{4{ofs[7]}}, ofs};
      if (diff[11])
        dacMap = 10'h000;
      else if (diff > {2'b00, DAC8_FULL})
        dacMap = DAC8_FULL;
      else
        dacMap = diff[9:0];
    end
  endfunction : dacMap

  always_comb begin
    pinsAnalog = s_q.ctrl1[CF1_PIN_HI:CF1_PIN_LO] != 2'b00;
    singleMode = s_q.ctrl2[CF2_SINGLE];
    avgOff     = s_q.ctrl2[CF2_AVGOFF];
    // a pin function change mid-pass must not aim the converter at the other pin use
    roundChan  = s_q.seqChan;
    if (pinsAnalog && s_q.seqChan == CH_EXT)
      roundChan = CH_ANALOG_INPUT_ONE;
    else if (!pinsAnalog && (s_q.seqChan == CH_ANALOG_INPUT_ONE || s_q.seqChan == CH_ANALOG_INPUT_TWO))
      roundChan = CH_EXT;
    convChan   = singleMode ? msm_chan_type'(s_q.ctrl2[CF2_SEL_HI:CF2_SEL_LO]) : roundChan;
    isTemp     = (s_q.adc.chan == CH_INT) || (s_q.adc.chan == CH_EXT);
    // temperature codes are signed quarter degrees, the rest unsigned
    // the sample code is gone by the store cycle, so a single sample is read back from the sum
    avgRes     = avgOff ? s_q.acc[9:0] : s_q.acc[13:4];
    storeVal   = (s_q.adc.chan == CH_INT) ? avgRes + {s_q.intOfs, 2'b00} : avgRes;
    cmpVal     = storeVal[9:2];
    limIdx     = {4'h0, s_q.adc.chan, 1'b0};
    limHi      = s_q.limits[limIdx[3:0]];
    limLo      = s_q.limits[limIdx[3:0] + 4'h1];
    if (isTemp) begin
      overHi  = $signed(cmpVal) > $signed(limHi);
      underLo = $signed(cmpVal) <= $signed(limLo);
    end else begin
      overHi  = cmpVal > limHi;
      underLo = cmpVal <= limLo;
    end
    dacCode = dacMap(storeVal,
                     (s_q.adc.chan == CH_INT) ? s_q.dacOfsI : s_q.dacOfsE,
                     s_q.ctrl3[CF3_DAC10]);

    // flags are only raised for unmasked channels
    s1Set = 8'h00;
    s2Set = 8'h00;
    if (s_q.state == ST_STORE) begin
      case (s_q.adc.chan)
        CH_SUPPLY: s2Set[1:0] = {underLo, overHi};
        CH_INT:    s1Set[1:0] = {underLo, overHi};
        CH_EXT:    s1Set[3:2] = {underLo, overHi};
        CH_ANALOG_INPUT_ONE:   s1Set[4]   = overHi | underLo;
        CH_ANALOG_INPUT_TWO:   s1Set[5]   = overHi | underLo;
        CH_ANALOG_INPUT_THREE:   s1Set[6]   = overHi | underLo;
        CH_ANALOG_INPUT_FOUR:   s1Set[7]   = overHi | underLo;
        default:   s1Set      = 8'h00;
      endcase
    end
    s1Set = s1Set & ~s_q.mask1;
    s2Set = s2Set & ~s_q.mask2;
    // status clears on read; a same-cycle event wins
    s1Clr  = (regReq.rd && regReq.addr == ADDR_STATUS1) ? 8'hff : 8'h00;
    s2Clr  = (regReq.rd && regReq.addr == ADDR_STATUS2) ? 8'hff : 8'h00;
    s1Next = (s_q.status1 & ~s1Clr) | s1Set;
    s2Next = (s_q.status2 & ~s2Clr) | s2Set;
    anyFlag = |(s1Next & ~s_q.mask1) || |(s2Next & ~s_q.mask2);

    rdMux = 8'h00;
    if (regReq.addr >= ADDR_LIM_BASE && regReq.addr <= ADDR_LIM_LAST) begin
      rdMux = s_q.limits[4'(regReq.addr - ADDR_LIM_BASE)];
    end else if (regReq.addr >= ADDR_RES_HI && regReq.addr <= ADDR_RES_HI_END) begin
      rdMux = s_q.results[3'(regReq.addr - ADDR_RES_HI)][9:2];
    end else begin
      case (regReq.addr)
        ADDR_STATUS1:   rdMux = s_q.status1;
        ADDR_STATUS2:   rdMux = s_q.status2;
        ADDR_SUP_LOW:   rdMux = {6'h00, s_q.results[CH_SUPPLY][1:0]};
        ADDR_TEMP_LOW:  rdMux = {4'h0, s_q.results[CH_EXT][1:0], s_q.results[CH_INT][1:0]};
        ADDR_AIN_LOW:   rdMux = {s_q.results[CH_ANALOG_INPUT_FOUR][1:0], s_q.results[CH_ANALOG_INPUT_THREE][1:0],
                                 s_q.results[CH_ANALOG_INPUT_TWO][1:0], s_q.results[CH_ANALOG_INPUT_ONE][1:0]};
        ADDR_CTRL1:     rdMux = s_q.ctrl1;
        ADDR_CTRL2:     rdMux = s_q.ctrl2;
        ADDR_CTRL3:     rdMux = s_q.ctrl3;
        ADDR_MASK1:     rdMux = s_q.mask1;
        ADDR_MASK2:     rdMux = s_q.mask2;
        ADDR_INT_OFS:   rdMux = s_q.intOfs;
        ADDR_DAC_OFS_I: rdMux = s_q.dacOfsI;
        ADDR_DAC_OFS_E: rdMux = s_q.dacOfsE;
        default:        rdMux = 8'h00;
      endcase
    end

    s_d            = s_q;
    s_d.adc.start  = 1'b0;
    s_d.adc.rst    = 1'b0;
    s_d.dac.update = 1'b0;
    s_d.status1    = s1Next;
    s_d.status2    = s2Next;
    s_d.alert      = s_q.ctrl1[CF1_POL] ? anyFlag : ~anyFlag;
    s_d.adc.pinsAnalog = pinsAnalog;
    if (regReq.rd)
      s_d.rdData = rdMux;

    if (regReq.wr) begin
      if (regReq.addr >= ADDR_LIM_BASE && regReq.addr <= ADDR_LIM_LAST) begin
        s_d.limits[4'(regReq.addr - ADDR_LIM_BASE)] = regReq.data;
      end else begin
        case (regReq.addr)
          ADDR_CTRL1:     s_d.ctrl1   = regReq.data;
          ADDR_CTRL2:     s_d.ctrl2   = regReq.data;
          ADDR_CTRL3:     s_d.ctrl3   = regReq.data;
          ADDR_MASK1:     s_d.mask1   = regReq.data;
          ADDR_MASK2:     s_d.mask2   = regReq.data;
          ADDR_INT_OFS:   s_d.intOfs  = regReq.data;
          ADDR_DAC_OFS_I: s_d.dacOfsI = regReq.data;
          ADDR_DAC_OFS_E: s_d.dacOfsE = regReq.data;
          default:        s_d.ctrl1   = s_q.ctrl1;
        endcase
      end
    end

    case (s_q.state)
      ST_IDLE: begin
        if (s_q.ctrl1[CF1_EN]) begin
          s_d.adc.chan   = convChan;
          // supply and temperatures never use the rail as reference
          s_d.adc.refVdd = s_q.ctrl3[CF3_REFVDD] && convChan >= CH_ANALOG_INPUT_ONE;
          s_d.acc        = 14'h0000;
          s_d.avgCnt     = 4'h0;
          s_d.state      = ST_START;
        end
      end
      ST_START: begin
        s_d.adc.start = 1'b1;
        s_d.state     = ST_WAIT;
      end
      ST_WAIT: begin
        if (adcRes.done) begin
          s_d.acc    = s_q.acc + (isTemp ? {{4{adcRes.code[9]}}, adcRes.code}
                                         : {4'h0, adcRes.code});
          s_d.avgCnt = s_q.avgCnt + 4'h1;
          s_d.state  = (avgOff || s_q.avgCnt == AVG_LAST) ? ST_STORE : ST_START;
        end
      end
      ST_STORE: begin
        s_d.results[s_q.adc.chan] = storeVal;
        if (isTemp) begin
          s_d.dac.update = 1'b1;
          if (s_q.adc.chan == CH_INT)
            s_d.dac.intCode = dacCode;
          else
            s_d.dac.extCode = dacCode;
        end
        s_d.seqChan = nextChan(s_q.adc.chan, pinsAnalog);
        s_d.state   = ST_IDLE;
      end
      default: s_d.state = ST_IDLE;
    endcase

    // serial activity wins over everything in the sequencer
    if (hostActive) begin
      s_d.state     = ST_IDLE;
      s_d.adc.start = 1'b0;
      s_d.adc.rst   = 1'b1;
      s_d.acc       = 14'h0000;
      s_d.avgCnt    = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q         <= '0;
      s_q.state   <= ST_IDLE;
      s_q.seqChan <= CH_SUPPLY;
      s_q.ctrl1   <= CTRL1_RST;
      s_q.ctrl2   <= CTRL2_RST;
      s_q.ctrl3   <= CTRL3_RST;
      s_q.mask1   <= MASK_RST;
      s_q.mask2   <= MASK_RST;
      s_q.intOfs  <= INT_OFS_RST;
      s_q.dacOfsI <= DAC_OFS_RST;
      s_q.dacOfsE <= DAC_OFS_RST;
      for (int i = 0; i < NUM_LIM; i = i + 2) begin
        s_q.limits[i]     <= LIM_HI_RST;
        s_q.limits[i + 1] <= LIM_LO_RST;
      end
      s_q.alert   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign adcCtl    = s_q.adc;
  assign dacOut    = s_q.dac;
  assign alert     = s_q.alert;
endmodule : measurement_sequencer_monitor

`default_nettype wire

// file: rtl/msm_pkg.sv
package msm_pkg;
  // register map
  localparam logic [7:0] ADDR_STATUS1    = 8'h00;
  localparam logic [7:0] ADDR_STATUS2    = 8'h01;
  localparam logic [7:0] ADDR_SUP_LOW    = 8'h03;
  localparam logic [7:0] ADDR_TEMP_LOW   = 8'h04;
  localparam logic [7:0] ADDR_AIN_LOW    = 8'h05;
  localparam logic [7:0] ADDR_RES_HI     = 8'h06;
  localparam logic [7:0] ADDR_CTRL1      = 8'h18;
  localparam logic [7:0] ADDR_CTRL2      = 8'h19;
  localparam logic [7:0] ADDR_CTRL3      = 8'h1a;
  localparam logic [7:0] ADDR_MASK1      = 8'h1d;
  localparam logic [7:0] ADDR_MASK2      = 8'h1e;
  localparam logic [7:0] ADDR_INT_OFS    = 8'h1f;
  localparam logic [7:0] ADDR_DAC_OFS_I  = 8'h21;
  localparam logic [7:0] ADDR_DAC_OFS_E  = 8'h22;
  localparam logic [7:0] ADDR_LIM_BASE   = 8'h2b;
  localparam int         NUM_CHAN        = 7;
  localparam int         NUM_LIM         = 14;
  localparam logic [7:0] ADDR_LIM_LAST   = 8'h38;
  localparam logic [7:0] ADDR_RES_HI_END = 8'h0c;

  // field positions
  localparam int CF1_EN     = 0;
  localparam int CF1_PIN_LO = 1;
  localparam int CF1_PIN_HI = 2;
  localparam int CF1_POL    = 3;
  localparam int CF2_SEL_LO = 0;
  localparam int CF2_SEL_HI = 2;
  localparam int CF2_SINGLE = 4;
  localparam int CF2_AVGOFF = 5;
  localparam int CF3_DAC10  = 1;
  localparam int CF3_REFVDD = 4;

  // reset values
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] CTRL2_RST   = 8'h00;
  localparam logic [7:0] CTRL3_RST   = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] INT_OFS_RST = 8'h00;
  localparam logic [7:0] DAC_OFS_RST = 8'hd8;
  localparam logic [7:0] LIM_HI_RST  = 8'hff;
  localparam logic [7:0] LIM_LO_RST  = 8'h00;

  localparam logic [3:0]  AVG_LAST   = 4'hf;
  localparam logic [9:0]  DAC10_FULL = 10'h3ff;
  localparam logic [9:0]  DAC8_FULL  = 10'h0ff;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b11,
    ST_STORE = 2'b10
  } msm_state_type;

  typedef enum logic [2:0] {
    CH_SUPPLY = 3'h0,
    CH_INT    = 3'h1,
    CH_EXT    = 3'h2,
    CH_ANALOG_INPUT_ONE   = 3'h3,
    CH_ANALOG_INPUT_TWO   = 3'h4,
    CH_ANALOG_INPUT_THREE   = 3'h5,
    CH_ANALOG_INPUT_FOUR   = 3'h6
  } msm_chan_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } msm_reg_req_type;

  typedef struct packed {
    logic         start;
    logic         rst;
    logic         refVdd;
    logic         pinsAnalog;
    msm_chan_type chan;
  } msm_adc_ctl_type;

  typedef struct packed {
    logic       done;
    logic [9:0] code;
  } msm_adc_res_type;

  typedef struct packed {
    logic       update;
    logic [9:0] intCode;
    logic [9:0] extCode;
  } msm_dac_type;

  typedef struct packed {
    msm_state_type                  state;
    msm_chan_type                   seqChan;
    logic [3:0]                     avgCnt;
    logic [13:0]                    acc;
    logic [7:0]                     ctrl1;
    logic [7:0]                     ctrl2;
    logic [7:0]                     ctrl3;
    logic [7:0]                     mask1;
    logic [7:0]                     mask2;
    logic [7:0]                     intOfs;
    logic [7:0]                     dacOfsI;
    logic [7:0]                     dacOfsE;
    logic [7:0]                     status1;
    logic [7:0]                     status2;
    logic [NUM_LIM-1:0][7:0]        limits;
    logic [NUM_CHAN-1:0][9:0]       results;
    logic [7:0]                     rdData;
    logic                           alert;
    msm_adc_ctl_type                adc;
    msm_dac_type                    dac;
  } msm_state_all_type;
endpackage : msm_pkg

// file: tb/msm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module msm_sva (
  // clock and reset
  input wire logic                     ref_clk,
  input wire logic                     nrst,
  // register access
  input wire logic                     hostActive,
  input wire msm_pkg::msm_reg_req_type regReq,
  input wire logic [7:0]               regRdData,
  // converter, outputs
  input wire msm_pkg::msm_adc_ctl_type adcCtl,
  input wire msm_pkg::msm_adc_res_type adcRes,
  input wire msm_pkg::msm_dac_type     dacOut,
  input wire logic                     alert
);
  import msm_pkg::*;
  logic       enSeen_q;
  logic       dac10_q;
  logic       avgOff_q;
  logic [7:0] ctrl2_q;
  logic [4:0] smpCnt_q;
  logic [2:0] chanLast_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // mode copies, enable and 10-bit ones sticky: stale dac codes from a 10-bit spell never trip the range check
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      enSeen_q <= 1'b0;
      dac10_q  <= 1'b0;
      avgOff_q <= 1'b0;
      ctrl2_q  <= CTRL2_RST;
      smpCnt_q <= 5'h00;
    end else begin
      if (regReq.wr && regReq.addr == ADDR_CTRL1 && regReq.data[CF1_EN]) enSeen_q <= 1'b1;
      if (regReq.wr && regReq.addr == ADDR_CTRL3 && regReq.data[CF3_DAC10]) dac10_q <= 1'b1;
      if (regReq.wr && regReq.addr == ADDR_CTRL2) avgOff_q <= regReq.data[CF2_AVGOFF];
      if (regReq.wr && regReq.addr == ADDR_CTRL2) ctrl2_q <= regReq.data;
      if (hostActive || dacOut.update || adcCtl.chan != chanLast_q) smpCnt_q <= 5'h00;
      else if (adcRes.done && smpCnt_q != 5'h1f) smpCnt_q <= smpCnt_q + 5'h01;
    end
    chanLast_q <= adcCtl.chan;
  end
  sequence hostHeld;
    hostActive ##1 hostActive;
  endsequence
  sequence hostQuiet;
    !hostActive ##1 !hostActive;
  endsequence
  chk_abort_hold: assert property (hostHeld |-> adcCtl.rst && !adcCtl.start)
    else $error("converter not held during host access");
  chk_abort_free: assert property (hostQuiet |-> !adcCtl.rst)
    else $error("converter reset without host access");
  chk_restart_soon: assert property ($fell(hostActive) && enSeen_q |-> ##[1:6] (adcCtl.start || hostActive))
    else $error("no restart after host access");
  chk_enable_gate: assert property (!enSeen_q |-> !adcCtl.start)
    else $error("conversion before enable");
  chk_fixed_ref: assert property (adcCtl.start && adcCtl.chan inside {CH_SUPPLY, CH_INT, CH_EXT} |-> !adcCtl.refVdd)
    else $error("supply or temperature on rail reference");
  chk_pin_pair: assert property (adcCtl.start && adcCtl.pinsAnalog |-> adcCtl.chan != CH_EXT)
    else $error("external sensor sampled with analog pins");
  chk_avg_count: assert property (dacOut.update |-> smpCnt_q == (avgOff_q ? 5'h01 : 5'h10))
    else $error("wrong sample count per result");
  chk_update_temp: assert property (dacOut.update |-> adcCtl.chan inside {CH_INT, CH_EXT})
    else $error("dac update from non-temperature channel");
  chk_dac_range: assert property (!dac10_q |-> dacOut.intCode <= DAC8_FULL && dacOut.extCode <= DAC8_FULL)
    else $error("8-bit dac code beyond full scale");
  chk_single_chan: assert property (adcCtl.start && ctrl2_q[CF2_SINGLE] |->
    adcCtl.chan == ctrl2_q[CF2_SEL_HI:CF2_SEL_LO])
    else $error("single mode converts another channel");
endmodule : msm_sva
`default_nettype wire

// file: tb/msm_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module msm_adc_model #(
  parameter logic [6:0][9:0] CODES = '0
) (
  // clock
  input wire logic                     ref_clk,
  // converter control and result
  input wire msm_pkg::msm_adc_ctl_type adcCtl,
  output var msm_pkg::msm_adc_res_type adcRes
);
  import msm_pkg::*;
  int         cnt  = 0;
  logic       slow = 1'b0;
  logic [9:0] last = 10'h000;
  initial adcRes = '0;
  // alternates prompt and slow answers; idle code is inverted so stale data is never fresh
  always @(posedge ref_clk) begin
    adcRes.done <= cnt == 1 && !adcCtl.rst;
    adcRes.code <= (cnt == 1) ? CODES[adcCtl.chan] : ~last;
    if (cnt == 1) last <= CODES[adcCtl.chan];
    if (adcCtl.rst) cnt <= 0;
    else if (adcCtl.start) begin
      cnt  <= slow ? 7 : 1;
      slow <= ~slow;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : msm_adc_model
`default_nettype wire

// file: tb/test_measurement_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_measurement_sequencer_monitor;
  import msm_pkg::*;
  localparam logic [9:0] SUP = 10'h02db, TINT = 10'h0064, TEXT = 10'h03d8;
  localparam logic [9:0] A1 = 10'h0100, A2 = 10'h0004, A3 = 10'h0200, A4 = 10'h0155;
  localparam logic [15:0] RSTRD [6] = '{16'h1800, 16'h1900, 16'h1a00, 16'h2bff, 16'h2c00, 16'h0200};
  localparam logic [15:0] SETUP [7] = '{16'h2bb5, 16'h2d18, 16'h30f6, 16'h3580, 16'h3855, 16'h1f02, 16'h1801};
  localparam logic [15:0] RESRD [8] = '{16'h06b6, 16'h0303, 16'h071b, 16'h08f6, 16'h0b80, 16'h0c55, 16'h0089, 16'h0101};
  logic            ref_clk    = 1'b0;
  logic            nrst       = 1'b0;
  logic            hostActive = 1'b0;
  msm_reg_req_type regReq     = '0;
  logic [7:0]      regRdData;
  msm_adc_ctl_type adcCtl;
  msm_adc_res_type adcRes;
  msm_dac_type     dacOut;
  logic            alert;
  int              errorCnt       = 0;
  int              samplesChecked = 0;
  logic [2:0]      seq[$];
  logic [2:0]      lastCh = 3'h7;
  logic            analog = 1'b0;
  logic            refAin = 1'b0;
  logic            got;
  logic [7:0]      rdv;
  measurement_sequencer_monitor DUT (.ref_clk(ref_clk), .nrst(nrst), .hostActive(hostActive), .regReq(regReq),
    .regRdData(regRdData), .adcCtl(adcCtl), .adcRes(adcRes), .dacOut(dacOut), .alert(alert));
  msm_adc_model #(.CODES({A4, A3, A2, A1, TEXT, TINT, SUP})) adcModel (.ref_clk(ref_clk), .adcCtl(adcCtl),
    .adcRes(adcRes));
  always #10 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // every access is framed by hostActive, as a serial transaction would be
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    hostActive <= 1'b1;
    regReq     <= '{wr: wr, rd: !wr, addr: a, data: d};
    @(posedge ref_clk);
    regReq.wr  <= 1'b0;
    regReq.rd  <= 1'b0;
    @(posedge ref_clk);
    hostActive <= 1'b0;
    rdv = regRdData;
  endtask : access
  task automatic waitSeq(input int n);
    for (int t = 0; t < 3000 && seq.size() < n; t++) @(posedge ref_clk);
    check(seq.size() >= n, 16'h0001);
  endtask : waitSeq
  task automatic waitStart();
    got = 1'b0;
    for (int t = 0; t < 200 && !got; t++) begin
      @(posedge ref_clk);
      got = adcCtl.start;
    end
  endtask : waitStart
  function automatic logic [2:0] nextCh(input logic [2:0] c);
    case (c)
      3'h0: nextCh = 3'h1;
      3'h1: nextCh = analog ? 3'h3 : 3'h2;
      3'h3: nextCh = 3'h4;
      3'h5: nextCh = 3'h6;
      3'h6: nextCh = 3'h0;
      default: nextCh = 3'h5;
    endcase
  endfunction : nextCh
  always @(posedge ref_clk) begin
    if (nrst && adcCtl.start && adcCtl.chan != lastCh) begin
      seq.push_back(adcCtl.chan);
      lastCh = adcCtl.chan;
      check(adcCtl.pinsAnalog, analog);
      if (adcCtl.chan >= CH_ANALOG_INPUT_ONE) check(adcCtl.refVdd, refAin);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({regRdData, 7'h00, alert}, 16'h0001);
    check(adcCtl, 16'h0000);
    foreach (RSTRD[i]) begin
      access(1'b0, RSTRD[i][15:8], 8'h00);
      check(rdv, RSTRD[i][7:0]);
    end
    $display("reset test done");
    foreach (SETUP[i]) access(1'b1, SETUP[i][15:8], SETUP[i][7:0]);
    waitSeq(6);
    check(seq[0], 16'h0000);
    for (int i = 1; i < 6; i++) check(seq[i], nextCh(seq[i-1]));
    check(alert, 16'h0000);
    check({dacOut.intCode, dacOut.extCode}, {10'h043, 10'h01e});
    foreach (RESRD[i]) begin
      access(1'b0, RESRD[i][15:8], 8'h00);
      check(rdv, RESRD[i][7:0]);
    end
    $display("round robin test done");
    access(1'b1, ADDR_CTRL3, 8'h12);
    refAin = 1'b1;
    access(1'b1, ADDR_CTRL1, 8'h0b);
    analog = 1'b1;
    seq.delete();
    waitSeq(7);
    for (int i = 1; i < 7; i++) check(seq[i], nextCh(seq[i-1]));
    check(alert, 16'h0001);
    check(dacOut.intCode, 10'h10c);
    $display("pin and polarity test done");
    for (int s = 0; s < 7; s += 6) begin
      access(1'b1, ADDR_CTRL2, 8'h10 | 8'(s));
      seq.delete();
      repeat (300) @(posedge ref_clk);
      check(seq.size() <= 1, 16'h0001);
      check(lastCh, 16'(s));
    end
    $display("single channel test done");
    access(1'b1, ADDR_CTRL2, 8'h31);
    repeat (100) @(posedge ref_clk);
    check(dacOut.intCode, 10'h10c);
    access(1'b0, ADDR_RES_HI + 8'h01, 8'h00);
    check(rdv, 16'h001b);
    $display("averaging off test done");
    waitStart();
    hostActive <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hostActive <= 1'b0;
    waitStart();
    check(got, 16'h0001);
    $display("abort test done");
    results();
  end
endmodule : test_measurement_sequencer_monitor
bind measurement_sequencer_monitor msm_sva u_sva (.ref_clk(ref_clk), .nrst(nrst), .hostActive(hostActive),
  .regReq(regReq), .regRdData(regRdData), .adcCtl(adcCtl), .adcRes(adcRes), .dacOut(dacOut), .alert(alert));
`default_nettype wire
